// >>> bench/nbadd_partner.sv
module nbadd_partner (
    // Clock
    input wire logic clk,
    // Data memory
    input wire logic [6:0] raddr,
    output logic [3:0] rdata,
    input wire logic we,
    input wire logic [6:0] waddr,
    input wire logic [3:0] wdata,
    // Working registers
    input wire logic [3:0] rsel,
    output logic [3:0] rrdata,
    input wire logic wr_we,
    input wire logic [3:0] wsel,
    input wire logic [3:0] wr_wdata
);
    timeunit 1ns;
    timeprecision 100ps;
    // Plain always, so that the bench may preload the arrays
    logic [3:0] mem_q [128];
    logic [3:0] wreg_q [16];
    assign rdata = mem_q[raddr];
    assign rrdata = wreg_q[rsel];
    always @(posedge clk) begin
        if (we) begin
            mem_q[waddr] <= wdata;
        end
        if (wr_we) begin
            wreg_q[wsel] <= wr_wdata;
        end
    end
endmodule

// >>> bench/nibble_add_carry_datapath_test.sv
module nibble_add_carry_datapath_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, rst_n, valid, hit, mwe, wwe, carry, zero;
    logic [15:0] instr;
    logic [6:0] raddr, waddr;
    logic [3:0] rdata, rsel, rrdata, wdata, wsel, wwdata, res;
    logic [3:0] m_e [128];
    logic [3:0] w_e [16];
    logic [3:0] res_e;
    logic carry_e;
    int mismatches, samples_checked;
    ////////////////////////////////////////////////////////////////////////
    nbadd_core nbadd_core_i (.CLK(clk), .RST_N(rst_n), .INSTR_VALID(valid), .INSTR(instr),
        .OP_HIT(hit), .MEM_RADDR(raddr), .MEM_RDATA(rdata), .WR_RSEL(rsel), .WR_RDATA(rrdata),
        .MEM_WE(mwe), .MEM_WADDR(waddr), .MEM_WDATA(wdata), .WR_WE(wwe), .WR_WSEL(wsel),
        .WR_WDATA(wwdata), .RESULT(res), .CARRY_FLAG(carry), .ZERO_FLAG(zero));
    nbadd_partner nbadd_partner_i (.clk(clk), .raddr(raddr), .rdata(rdata), .we(mwe),
        .waddr(waddr), .wdata(wdata), .rsel(rsel), .rrdata(rrdata), .wr_we(wwe),
        .wsel(wsel), .wr_wdata(wwdata));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [6:0] e, input logic [6:0] g);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wrap_up();
        if (mismatches == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // One instruction, then the idle cycle that shows the write pulse has ended
    task automatic run(input logic [15:0] ins, input logic v, input logic h, input logic mem,
                       input logic cy, input logic wb);
        logic [4:0] s;
        s = {1'b0, mem ? m_e[ins[6:0]] : w_e[ins[3:0]]} + {1'b0, mem ? res_e : ins[7:4]}
            + {4'h0, cy & carry_e};
        @(posedge clk);
        valid <= v;
        instr <= ins;
        #1 chk("op_hit", 7'(h), 7'(hit));
        chk("mem_raddr", ins[6:0], raddr);
        chk("wr_rsel", 7'(ins[3:0]), 7'(rsel));
        @(posedge clk);
        valid <= 1'b0;
        if (h) begin
            res_e = s[3:0];
            carry_e = s[4];
            if (wb && mem) m_e[ins[6:0]] = s[3:0];
            if (wb && !mem) w_e[ins[3:0]] = s[3:0];
        end
        #1 chk("result", 7'(res_e), 7'(res));
        chk("carry_flag", 7'(carry_e), 7'(carry));
        chk("zero_flag", 7'(res_e == 4'h0), 7'(zero));
        chk("mem_we", 7'(h & mem & wb), 7'(mwe));
        chk("wr_we", 7'(h & !mem & wb), 7'(wwe));
        if (h && wb && mem) chk("mem_waddr", ins[6:0], waddr);
        if (h && wb && mem) chk("mem_wdata", 7'(s[3:0]), 7'(wdata));
        if (h && wb && !mem) chk("wr_wsel", 7'(ins[3:0]), 7'(wsel));
        if (h && wb && !mem) chk("wr_wdata", 7'(s[3:0]), 7'(wwdata));
        @(posedge clk);
        #1 chk("we_idle", 7'h00, 7'({mwe, wwe}));
        chk("memory", 7'(m_e[ins[6:0]]), 7'(nbadd_partner_i.mem_q[ins[6:0]]));
        chk("wreg", 7'(w_e[ins[3:0]]), 7'(nbadd_partner_i.wreg_q[ins[3:0]]));
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic sc_mem();
        run({nbadd_pkg::OPC_ADD_MEM, 7'h7F}, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
        run({nbadd_pkg::OPC_ADC_MEM, 7'h0B}, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
        run({nbadd_pkg::OPC_ADCWB_MEM, 7'h00}, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
        run({nbadd_pkg::OPC_ADD_MEM, 7'h0F}, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
        run({nbadd_pkg::OPC_ADC_MEM, 7'h0F}, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
        run({nbadd_pkg::OPC_ADD_MEM, 7'h05}, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
        run({nbadd_pkg::OPC_ADC_MEM, 7'h05}, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
    endtask
    task automatic sc_imm();
        run({nbadd_pkg::OPC_ADC_IMM, 8'hFF}, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
        run({nbadd_pkg::OPC_ADCWB_IMM, 8'h10}, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
        run({nbadd_pkg::OPC_ADD_IMM, 8'hF3}, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
        run({nbadd_pkg::OPC_ADC_IMM, 8'h0C}, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
        run({nbadd_pkg::OPC_ADCWB_IMM, 8'h70}, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
        run({nbadd_pkg::OPC_ADC_IMM, 8'h05}, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
    endtask
    // Foreign opcode, then an add opcode without the valid qualifier
    task automatic sc_refuse();
        run(16'h2812, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
        run({nbadd_pkg::OPC_ADCWB_MEM, 7'h05}, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
    endtask
    // Reset in mid-run clears result, flags and write registers at once
    task automatic sc_reset();
        @(posedge clk);
        rst_n <= 1'b0;
        #1 chk("reset_state", 7'h00, {res, carry, zero, mwe});
        chk("reset_wr", 7'h00, {wwe, 2'h0, wwdata});
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        res_e = 4'h0;
        carry_e = 1'b0;
        run({nbadd_pkg::OPC_ADC_MEM, 7'h0B}, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        repeat (400) @(posedge clk);
        mismatches++;
        wrap_up();
    end
    initial begin
        rst_n = 1'b0;
        valid = 1'b0;
        instr = 16'h0000;
        res_e = 4'h0;
        carry_e = 1'b0;
        for (int i = 0; i < 128; i++) begin
            m_e[i] = i[3:0] ^ 4'hA;
            nbadd_partner_i.mem_q[i] = m_e[i];
            if (i < 16) w_e[i] = ~i[3:0];
            if (i < 16) nbadd_partner_i.wreg_q[i] = w_e[i];
        end
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        #1 chk("reset_state", 7'h00, {res, carry, zero, mwe});
        sc_mem();
        sc_imm();
        sc_refuse();
        sc_reset();
        wrap_up();
    end
endmodule

// >>> common/nbadd_alu_if.sv
interface nbadd_alu_if;
    logic [nbadd_pkg::NIB_W-1:0] a;
    logic [nbadd_pkg::NIB_W-1:0] b;
    logic cin;
    logic [nbadd_pkg::NIB_W-1:0] sum;
    logic cout;
    logic zero;

    modport req (output a, output b, output cin, input sum, input cout, input zero);
    modport alu (input a, input b, input cin, output sum, output cout, output zero);
endinterface

// >>> common/nbadd_pkg.sv
package nbadd_pkg;
    // Widths
    localparam int unsigned NIB_W = 4;
    localparam int unsigned ADDR_W = 7;
    localparam int unsigned INSTR_W = 16;
    localparam int unsigned WSEL_W = 4;

    // Opcode field positions
    localparam int unsigned MEM_OPC_LSB = 7;
    localparam int unsigned IMM_OPC_LSB = 8;
    localparam int unsigned IMM_LSB = 4;
    localparam int unsigned WSEL_LSB = 0;
    localparam int unsigned ADDR_LSB = 0;

    // Memory-operand opcodes, bits 15..7
    localparam logic [8:0] OPC_ADC_MEM = 9'h020;
    localparam logic [8:0] OPC_ADCWB_MEM = 9'h012;
    localparam logic [8:0] OPC_ADD_MEM = 9'h030;

    // Register-immediate opcodes, bits 15..8
    localparam logic [7:0] OPC_ADC_IMM = 8'h0C;
    localparam logic [7:0] OPC_ADCWB_IMM = 8'h0D;
    localparam logic [7:0] OPC_ADD_IMM = 8'h1C;

    // Reset values
    localparam logic [3:0] RESULT_RST = 4'h0;
    localparam logic CARRY_RST = 1'h0;
    localparam logic ZERO_RST = 1'h0;

    typedef enum logic [6:0] {
        OP_NONE = 7'h01,
        OP_ADC_MEM = 7'h02,
        OP_ADC_IMM = 7'h04,
        OP_ADCWB_MEM = 7'h08,
        OP_ADCWB_IMM = 7'h10,
        OP_ADD_MEM = 7'h20,
        OP_ADD_IMM = 7'h40
    } nbadd_op_t;

    function automatic nbadd_op_t op_decode(input logic valid, input logic [15:0] instr);
        nbadd_op_t op;
        op = OP_NONE;
        if (!valid) begin
            op = OP_NONE;
        end else if (instr[15:MEM_OPC_LSB] == OPC_ADC_MEM) begin
            op = OP_ADC_MEM;
        end else if (instr[15:MEM_OPC_LSB] == OPC_ADCWB_MEM) begin
            op = OP_ADCWB_MEM;
        end else if (instr[15:MEM_OPC_LSB] == OPC_ADD_MEM) begin
            op = OP_ADD_MEM;
        end else if (instr[15:IMM_OPC_LSB] == OPC_ADC_IMM) begin
            op = OP_ADC_IMM;
        end else if (instr[15:IMM_OPC_LSB] == OPC_ADCWB_IMM) begin
            op = OP_ADCWB_IMM;
        end else if (instr[15:IMM_OPC_LSB] == OPC_ADD_IMM) begin
            op = OP_ADD_IMM;
        end
        return op;
    endfunction
endpackage

// >>> core/nbadd_adder.sv
module nbadd_adder (
    nbadd_alu_if.alu alu
);
    logic [nbadd_pkg::NIB_W:0] full;

    assign full = {1'h0, alu.a} + {1'h0, alu.b} + {{nbadd_pkg::NIB_W{1'h0}}, alu.cin};
    assign alu.sum = full[nbadd_pkg::NIB_W-1:0];
    assign alu.cout = full[nbadd_pkg::NIB_W];
    assign alu.zero = (full[nbadd_pkg::NIB_W-1:0] == {nbadd_pkg::NIB_W{1'h0}});
endmodule

// >>> core/nbadd_core.sv
// Notes on behaviour
// - Memory add-with-carry loads result, memory kept.
// - Immediate add-with-carry loads result register only.
// - Memory add-with-carry writes result and memory.
// - Immediate add-with-carry writes result and working register.
// - Plain memory add ignores incoming carry.
// - Plain immediate add ignores incoming carry.
// - Address bits 6-0; immediate 7-4; register 3-0.
module nbadd_core (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // Instruction from fetch
    input wire logic INSTR_VALID,
    input wire logic [15:0] INSTR,
    output logic OP_HIT,
    // Data memory read
    output logic [6:0] MEM_RADDR,
    input wire logic [3:0] MEM_RDATA,
    // Working register read
    output logic [3:0] WR_RSEL,
    input wire logic [3:0] WR_RDATA,
    // Data memory writeback
    output logic MEM_WE,
    output logic [6:0] MEM_WADDR,
    output logic [3:0] MEM_WDATA,
    // Working register writeback
    output logic WR_WE,
    output logic [3:0] WR_WSEL,
    output logic [3:0] WR_WDATA,
    // Architectural state
    output logic [3:0] RESULT,
    output logic CARRY_FLAG,
    output logic ZERO_FLAG
);
    ////////////////////////////////////////////////////////////////////////////////
    nbadd_pkg::nbadd_op_t op;
    logic is_mem;
    logic use_cin;
    logic [3:0] imm;
    logic [3:0] result_q;
    logic carry_q;
    logic zero_q;
    logic mem_we_q;
    logic [6:0] mem_waddr_q;
    logic [3:0] mem_wdata_q;
    logic wr_we_q;
    logic [3:0] wr_wsel_q;
    logic [3:0] wr_wdata_q;

    nbadd_alu_if alu_bus ();

    nbadd_adder u_adder (
        .alu(alu_bus.alu)
    );

    ////////////////////////////////////////////////////////////////////////////////
    assign op = nbadd_pkg::op_decode(INSTR_VALID, INSTR);
    assign OP_HIT = (op != nbadd_pkg::OP_NONE);
    assign is_mem = (op == nbadd_pkg::OP_ADC_MEM) || (op == nbadd_pkg::OP_ADCWB_MEM)
        || (op == nbadd_pkg::OP_ADD_MEM);
    // Plain adds drop the carry here, not in the adder, so the adder stays generic
    assign use_cin = (op == nbadd_pkg::OP_ADC_MEM) || (op == nbadd_pkg::OP_ADC_IMM)
        || (op == nbadd_pkg::OP_ADCWB_MEM) || (op == nbadd_pkg::OP_ADCWB_IMM);

    // Read ports follow the instruction's operand bits directly so memory answers in the same cycle
    assign MEM_RADDR = INSTR[nbadd_pkg::ADDR_LSB +: nbadd_pkg::ADDR_W];
    assign WR_RSEL = INSTR[nbadd_pkg::WSEL_LSB +: nbadd_pkg::WSEL_W];
    assign imm = INSTR[nbadd_pkg::IMM_LSB +: nbadd_pkg::NIB_W];

    assign alu_bus.a = is_mem ? MEM_RDATA : WR_RDATA;
    assign alu_bus.b = is_mem ? result_q : imm;
    assign alu_bus.cin = use_cin & carry_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Result register and flags
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            result_q <= nbadd_pkg::RESULT_RST;
            carry_q <= nbadd_pkg::CARRY_RST;
            zero_q <= nbadd_pkg::ZERO_RST;
        end else if (OP_HIT) begin
            result_q <= alu_bus.sum;
            carry_q <= alu_bus.cout;
            zero_q <= alu_bus.zero;
        end
    end

    // Data memory writeback, one cycle after the instruction
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            mem_we_q <= 1'h0;
            mem_waddr_q <= 7'h00;
            mem_wdata_q <= 4'h0;
        end else begin
            mem_we_q <= (op == nbadd_pkg::OP_ADCWB_MEM);
            if (op == nbadd_pkg::OP_ADCWB_MEM) begin
                mem_waddr_q <= MEM_RADDR;
                mem_wdata_q <= alu_bus.sum;
            end
        end
    end

    // Working register writeback
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            wr_we_q <= 1'h0;
            wr_wsel_q <= 4'h0;
            wr_wdata_q <= 4'h0;
        end else begin
            wr_we_q <= (op == nbadd_pkg::OP_ADCWB_IMM);
            if (op == nbadd_pkg::OP_ADCWB_IMM) begin
                wr_wsel_q <= WR_RSEL;
                wr_wdata_q <= alu_bus.sum;
            end
        end
    end

    assign RESULT = result_q;
    assign CARRY_FLAG = carry_q;
    assign ZERO_FLAG = zero_q;
    assign MEM_WE = mem_we_q;
    assign MEM_WADDR = mem_waddr_q;
    assign MEM_WDATA = mem_wdata_q;
    assign WR_WE = wr_we_q;
    assign WR_WSEL = wr_wsel_q;
    assign WR_WDATA = wr_wdata_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Reference sums, independent of the adder
    logic [4:0] ref_mc;
    logic [4:0] ref_m;
    logic [4:0] ref_ic;
    logic [4:0] ref_i;
    logic [3:0] imm_ref;

    // Five bits wide, so the carry out lands in bit 4
    function automatic logic [4:0] ref_add(input logic [3:0] x, input logic [3:0] y,
                                           input logic c);
        return {1'h0, x} + {1'h0, y} + {4'h0, c};
    endfunction

    assign imm_ref = INSTR[7:4];
    assign ref_mc = ref_add(MEM_RDATA, result_q, carry_q);
    assign ref_m = ref_add(MEM_RDATA, result_q, 1'h0);
    assign ref_ic = ref_add(WR_RDATA, imm_ref, carry_q);
    assign ref_i = ref_add(WR_RDATA, imm_ref, 1'h0);

    default clocking cb @(posedge CLK); endclocking
    // Attempts in flight when reset falls are dropped; reset values are left to the bench
    default disable iff (!RST_N);

    // Result, carry flag and write pulses, one cycle after each opcode is taken
    a_adc_mem_sum: assert property (
        (op == nbadd_pkg::OP_ADC_MEM) |=> ({CARRY_FLAG, RESULT} == $past(ref_mc))
            && !MEM_WE && !WR_WE)
        else $error("memory add-with-carry result wrong");
    a_adc_imm_sum: assert property (
        (op == nbadd_pkg::OP_ADC_IMM) |=> ({CARRY_FLAG, RESULT} == $past(ref_ic))
            && !MEM_WE && !WR_WE)
        else $error("immediate add-with-carry result wrong");
    a_adcwb_mem_write: assert property (
        (op == nbadd_pkg::OP_ADCWB_MEM) |=> MEM_WE && (MEM_WDATA == RESULT)
            && (MEM_WADDR == $past(INSTR[6:0])) && ({CARRY_FLAG, RESULT} == $past(ref_mc)))
        else $error("memory writeback add wrong");
    a_adcwb_wr_write: assert property (
        (op == nbadd_pkg::OP_ADCWB_IMM) |=> WR_WE && (WR_WDATA == RESULT)
            && (WR_WSEL == $past(INSTR[3:0])) && ({CARRY_FLAG, RESULT} == $past(ref_ic)))
        else $error("register writeback add wrong");
    a_add_mem_nocarry: assert property (
        (op == nbadd_pkg::OP_ADD_MEM) |=> ({CARRY_FLAG, RESULT} == $past(ref_m)) && !MEM_WE)
        else $error("plain memory add wrong");
    a_add_imm_nocarry: assert property (
        (op == nbadd_pkg::OP_ADD_IMM) |=> ({CARRY_FLAG, RESULT} == $past(ref_i)) && !WR_WE)
        else $error("plain immediate add wrong");

    // Operand routing, flags and idle behaviour
    a_mem_read_addr: assert property (
        is_mem |-> (MEM_RADDR == INSTR[6:0]) && (alu_bus.a == MEM_RDATA))
        else $error("memory operand address wrong");
    a_mem_second_operand: assert property (
        is_mem |-> (alu_bus.b == result_q))
        else $error("memory add second operand is not the result register");
    a_imm_operands: assert property (
        (OP_HIT && !is_mem) |-> (WR_RSEL == INSTR[3:0]) && (alu_bus.b == INSTR[7:4])
            && (alu_bus.a == WR_RDATA))
        else $error("immediate operand fields wrong");
    a_plain_no_cin: assert property (
        ((op == nbadd_pkg::OP_ADD_MEM) || (op == nbadd_pkg::OP_ADD_IMM)) |-> !alu_bus.cin)
        else $error("plain add used the carry");
    a_zero_flag: assert property (
        OP_HIT |=> (ZERO_FLAG == (RESULT == 4'h0)))
        else $error("zero flag wrong");
    a_idle_hold: assert property (
        !OP_HIT |=> $stable({RESULT, CARRY_FLAG, ZERO_FLAG}) && !MEM_WE && !WR_WE)
        else $error("state changed without an add");

    // Write strobes, the words they carry, and the valid qualifier on decode
    a_mem_wb_hold: assert property (
        (op != nbadd_pkg::OP_ADCWB_MEM) |=> $stable({MEM_WADDR, MEM_WDATA}))
        else $error("memory write address or data moved");
    a_wr_wb_hold: assert property (
        (op != nbadd_pkg::OP_ADCWB_IMM) |=> $stable({WR_WSEL, WR_WDATA}))
        else $error("register write select or data moved");
    a_mem_pulse_source: assert property (
        MEM_WE |-> $past(op == nbadd_pkg::OP_ADCWB_MEM))
        else $error("memory write strobe without a writeback add");
    a_wr_pulse_source: assert property (
        WR_WE |-> $past(op == nbadd_pkg::OP_ADCWB_IMM))
        else $error("register write strobe without a writeback add");
    a_mem_wb_data: assert property (
        MEM_WE |-> (MEM_WDATA == RESULT))
        else $error("memory write data differs from the result register");
    a_wr_wb_data: assert property (
        WR_WE |-> (WR_WDATA == RESULT))
        else $error("register write data differs from the result register");
    a_hit_qualified: assert property (
        !INSTR_VALID |-> !OP_HIT)
        else $error("add decoded without a valid instruction");

    // Main scenarios
    c_adc_carry_in: cover property ((op == nbadd_pkg::OP_ADC_MEM) && carry_q);
    c_mem_writeback: cover property (op == nbadd_pkg::OP_ADCWB_MEM ##1 MEM_WE);
    c_imm_carry_out: cover property ((op == nbadd_pkg::OP_ADD_IMM) ##1 CARRY_FLAG && ZERO_FLAG);
    c_back_to_back: cover property (OP_HIT ##1 OP_HIT ##1 OP_HIT);
    c_reg_writeback: cover property ((op == nbadd_pkg::OP_ADCWB_IMM) ##1 WR_WE);
endmodule
